// ==== common/acs_defs.svh ====
// constants of the adc channel sequencer: register offsets, field positions,
// reset values, channel codes and averaging counts.
// assumes 8-bit registers on a plain strobe port; included by bare name.
// ============================================================================
// Functional notes
// - after reset round-robin is chosen but monitoring stays off, no conversions
// - host writes 1 to monitor enable bit to start conversions
// - round-robin order: supply, internal temp, diode or inputs 1-2, inputs 3-8
// - after last analog input the sequence restarts at supply by itself
// - third slot is diode or two analog inputs depending on pin configuration
// - single-channel select bit (bit 4 at 19h) turns round-robin off
// - in single-channel mode the four-bit channel select field picks the channel
// - field zero selects supply, field one selects internal temperature
// - single-channel conversions follow each other back to back
// - any host access halts conversions; they resume when the access ends
// - reference amplifier powered only while monitoring is enabled
// - temperature results are 10-bit twos-complement codes
// - one temperature lsb is a quarter degree celsius
// - internal temperature offset register is added before storing
// - diode temperature averaged over sixteen measurements before storing
// - stored temperatures compared with their high and low limit registers
// - supply code is straight binary, 7.0 V gives 3ff
// - host access aborts conversion in progress and resets the converter
// - averaging on after reset; bit 5 of 19h turns it off
// - supply lsbs stored at 03h, supply msbs at 06h
`ifndef ACS_DEFS_SVH
`define ACS_DEFS_SVH

// ============================================================================
// register offsets
`define ACS_ADR_STAT      8'h00
`define ACS_ADR_LSB_A     8'h03
`define ACS_ADR_LSB_B     8'h04
`define ACS_ADR_LSB_C     8'h05
`define ACS_ADR_MSB_FIRST 8'h06
`define ACS_ADR_MSB_LAST  8'h0f
`define ACS_ADR_CFG1      8'h18
`define ACS_ADR_CFG2      8'h19
`define ACS_ADR_TOFS      8'h1f
`define ACS_ADR_LIM_FIRST 8'h25
`define ACS_ADR_LIM_LAST  8'h28

// ============================================================================
// field positions
`define ACS_CFG1_MON      0
`define ACS_CFG1_AINPINS  2
`define ACS_CFG2_SINGLE   4
`define ACS_CFG2_AVGOFF   5

// ============================================================================
// reset values
`define ACS_RST_CFG1      8'h00
`define ACS_RST_CFG2      8'h00
`define ACS_RST_TOFS      8'h00
`define ACS_RST_LIM_IH    8'h64
`define ACS_RST_LIM_IL    8'hc9
`define ACS_RST_LIM_EH    8'hff
`define ACS_RST_LIM_EL    8'h00

// ============================================================================
// channel codes and averaging
`define ACS_CH_VDD        4'h0
`define ACS_CH_INT        4'h1
`define ACS_CH_EXT        4'h2
`define ACS_CH_AIN2       4'h3
`define ACS_CH_AIN3       4'h4
`define ACS_CH_LAST       4'h9
`define ACS_AVG_N         16
`define ACS_AVG_SHIFT     4

`endif

// ==== common/acs_pkg.sv ====
// types of the adc channel sequencer: sequencer states and the state record.
// assumes acs_defs.svh supplies the numeric constants.
package acs_pkg;

    // ========================================================================
    // sequencer states
    typedef enum logic [1:0] {
        ACS_IDLE,
        ACS_CONV,
        ACS_HALT
    } acs_state_type;

    // ========================================================================
    // register state of the sequencer apart from the averaging accumulator
    typedef struct packed {
        acs_state_type   st;
        logic [3:0]      chan;
        logic [7:0]      cfg1;
        logic [7:0]      cfg2;
        logic [7:0]      tofs;
        logic [3:0][7:0] lim;    // int high, int low, ext high, ext low
        logic [9:0][9:0] val;    // one result per channel code
        logic [3:0]      flag;   // int over, int under, ext over, ext under
        logic [7:0]      rdata;
        logic            start;
        logic            abort;
    } acs_regs_type;

endpackage

// ==== rtl/acs_avg_acc.sv ====
// running sum for temperature averaging over a fixed number of samples.
// assumes samples are signed and arrive on the caller's clock.
`timescale 1ns/1ps
`default_nettype none

module acs_avg_acc
    import acs_pkg::*;
#(
    parameter int DW    = 10,
    parameter int N     = 16,
    parameter int SHIFT = 4
) (
    // clock and reset
    input  wire logic          ref_clk_i,
    input  wire logic          rst_i,
    // sample side
    input  wire logic          clr_i,
    input  wire logic          add_i,
    input  wire logic [DW-1:0] data_i,
    // result side
    output logic               last_o,
    output logic      [DW-1:0] mean_o
);
    localparam int SW = DW + SHIFT;
    localparam int CW = $clog2(N) + 1;

    typedef struct packed {
        logic [SW-1:0] sum;
        logic [CW-1:0] cnt;
    } acs_acc_type;

    acs_acc_type s_ff;
    acs_acc_type nxt_s;
    logic [SW-1:0] total;

    // the mean includes the sample now arriving, so no extra cycle is spent
    always_comb begin
        total  = s_ff.sum + {{SHIFT{data_i[DW-1]}}, data_i};
        mean_o = total[SW-1:SHIFT];
        last_o = (s_ff.cnt == CW'(N - 1));
        nxt_s  = s_ff;
        if (clr_i) begin
            nxt_s = '0;
        end else if (add_i) begin
            nxt_s.sum = total;
            nxt_s.cnt = s_ff.cnt + 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            s_ff <= '0;
        end else begin
            s_ff <= nxt_s;
        end
    end

endmodule // acs_avg_acc

`default_nettype wire

// ==== rtl/acs_sequencer.sv ====
// conversion sequencer: channel order, host-access suspension, averaging,
// offset, result storage, limit flags and the configuration registers.
// assumes the converter, its done pulse and the serial front end share ref_clk_i.
//
// Implementation choices: the placing of the registers and the strobed register port.
`timescale 1ns/1ps
`default_nettype none
`include "acs_defs.svh"

module acs_sequencer
    import acs_pkg::*;
(
    // clock and reset
    input  wire logic       ref_clk_i,
    input  wire logic       rst_i,
    // register port
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wr_data_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rd_data_o,
    // serial front end
    input  wire logic       host_busy_i,
    // converter
    input  wire logic       adc_done_i,
    input  wire logic [9:0] adc_data_i,
    output logic            adc_start_o,
    output logic            adc_abort_o,
    output logic      [3:0] adc_chan_o,
    output logic            ref_power_o,
    // limit flags
    output logic      [3:0] limit_flag_o
);

    // ========================================================================
    // state
    acs_regs_type s_ff;
    acs_regs_type nxt_s;

    logic       busy;
    logic       mon_en;
    logic       single;
    logic       avg_on;
    logic       diode;
    logic       is_temp;
    logic       avg_add;
    logic       avg_clr;
    logic       avg_last;
    logic [9:0] avg_mean;
    logic [9:0] result;
    logic [3:0] sel_chan;
    logic [3:0] step_chan;

    // ========================================================================
    // averaging accumulator
    acs_avg_acc #(
        .DW    (10),
        .N     (`ACS_AVG_N),
        .SHIFT (`ACS_AVG_SHIFT)
    ) u_avg (
        .ref_clk_i (ref_clk_i),
        .rst_i     (rst_i),
        .clr_i     (avg_clr),
        .add_i     (avg_add),
        .data_i    (adc_data_i),
        .last_o    (avg_last),
        .mean_o    (avg_mean)
    );

    // ========================================================================
    // helpers
    // out-of-range field values fall back to supply rather than a dead channel
    function automatic logic [3:0] pick_single(input logic [3:0] f, input logic dio);
        logic [3:0] c;
        c = f;
        if (f > `ACS_CH_LAST) begin
            c = `ACS_CH_VDD;
        end else if (dio && f == `ACS_CH_AIN2) begin
            c = `ACS_CH_EXT;                              // pins belong to the diode
        end
        return c;
    endfunction

    // round-robin successor of a channel
    function automatic logic [3:0] rr_next(input logic [3:0] c, input logic dio);
        logic [3:0] n;
        n = c + 4'h1;
        if (c >= `ACS_CH_LAST) begin
            n = `ACS_CH_VDD;
        end else if (c == `ACS_CH_EXT && dio) begin
            n = `ACS_CH_AIN3;
        end
        return n;
    endfunction

    // register read mux; reserved and unmapped locations read zero
    function automatic logic [7:0] rd_mux(input logic [7:0] a, input acs_regs_type r);
        logic [7:0] d;
        d = 8'h00;
        if (a >= `ACS_ADR_MSB_FIRST && a <= `ACS_ADR_MSB_LAST) begin
            d = r.val[4'(a - `ACS_ADR_MSB_FIRST)][9:2];
        end else if (a >= `ACS_ADR_LIM_FIRST && a <= `ACS_ADR_LIM_LAST) begin
            d = r.lim[2'(a - `ACS_ADR_LIM_FIRST)];
        end else begin
            case (a)
                `ACS_ADR_STAT: begin
                    d = {4'h0, r.flag};
                end
                `ACS_ADR_LSB_A: begin
                    d = {4'h0, r.val[1][1:0], r.val[0][1:0]};
                end
                `ACS_ADR_LSB_B: begin
                    d = {r.val[5][1:0], r.val[4][1:0], r.val[3][1:0], r.val[2][1:0]};
                end
                `ACS_ADR_LSB_C: begin
                    d = {r.val[9][1:0], r.val[8][1:0], r.val[7][1:0], r.val[6][1:0]};
                end
                `ACS_ADR_CFG1: begin
                    d = r.cfg1;
                end
                `ACS_ADR_CFG2: begin
                    d = r.cfg2;
                end
                `ACS_ADR_TOFS: begin
                    d = r.tofs;
                end
                default: begin
                    d = 8'h00;
                end
            endcase
        end
        return d;
    endfunction

    // ========================================================================
    // decoded configuration
    always_comb begin
        busy      = host_busy_i | wr_i | rd_i;
        mon_en    = s_ff.cfg1[`ACS_CFG1_MON];
        single    = s_ff.cfg2[`ACS_CFG2_SINGLE];
        avg_on    = ~s_ff.cfg2[`ACS_CFG2_AVGOFF];
        diode     = ~s_ff.cfg1[`ACS_CFG1_AINPINS];
        sel_chan  = pick_single(s_ff.cfg2[3:0], diode);
        step_chan = single ? sel_chan : rr_next(s_ff.chan, diode);
        is_temp   = (s_ff.chan == `ACS_CH_INT) ||
                    (s_ff.chan == `ACS_CH_EXT && diode);
    end

    // ========================================================================
    // result path: average, then offset on the internal sensor
    always_comb begin
        result = (is_temp && avg_on) ? avg_mean : adc_data_i;
        if (s_ff.chan == `ACS_CH_INT) begin
            result = result + {{2{s_ff.tofs[7]}}, s_ff.tofs};
        end
    end

    // ========================================================================
    // next state
    always_comb begin
        nxt_s       = s_ff;
        nxt_s.start = 1'b0;
        nxt_s.abort = 1'b0;
        avg_add     = 1'b0;
        avg_clr     = 1'b0;

        // register writes
        if (wr_i) begin
            if (addr_i >= `ACS_ADR_LIM_FIRST && addr_i <= `ACS_ADR_LIM_LAST) begin
                nxt_s.lim[2'(addr_i - `ACS_ADR_LIM_FIRST)] = wr_data_i;
            end else begin
                case (addr_i)
                    `ACS_ADR_CFG1: begin
                        nxt_s.cfg1 = wr_data_i;
                    end
                    `ACS_ADR_CFG2: begin
                        nxt_s.cfg2 = wr_data_i;
                    end
                    `ACS_ADR_TOFS: begin
                        nxt_s.tofs = wr_data_i;
                    end
                    default: begin
                    end
                endcase
            end
        end

        // register reads land one cycle after the strobe
        if (rd_i) begin
            nxt_s.rdata = rd_mux(addr_i, s_ff);
        end

        // sequencer
        case (s_ff.st)
            ACS_IDLE: begin
                // no conversion is ever started while monitoring is off
                if (mon_en && !busy) begin
                    nxt_s.chan  = single ? sel_chan : `ACS_CH_VDD;
                    nxt_s.start = 1'b1;
                    nxt_s.st    = ACS_CONV;
                end
            end
            ACS_CONV: begin
                if (busy) begin
                    // partial sums are dropped since the converter restarts cold
                    nxt_s.abort = 1'b1;
                    avg_clr     = 1'b1;
                    nxt_s.st    = ACS_HALT;
                end else if (adc_done_i) begin
                    nxt_s.start = 1'b1;
                    if (is_temp && avg_on && !avg_last) begin
                        avg_add = 1'b1;
                    end else begin
                        avg_clr = 1'b1;
                        nxt_s.val[s_ff.chan] = result;
                        if (s_ff.chan == `ACS_CH_INT) begin
                            nxt_s.flag[0] = $signed(result[9:2]) >  $signed(s_ff.lim[0]);
                            nxt_s.flag[1] = $signed(result[9:2]) <= $signed(s_ff.lim[1]);
                        end else if (is_temp) begin
                            nxt_s.flag[2] = $signed(result[9:2]) >  $signed(s_ff.lim[2]);
                            nxt_s.flag[3] = $signed(result[9:2]) <= $signed(s_ff.lim[3]);
                        end
                        nxt_s.chan = step_chan;
                    end
                end
            end
            ACS_HALT: begin
                if (!busy) begin
                    if (mon_en) begin
                        // round-robin resumes the interrupted slot
                        nxt_s.chan  = single ? sel_chan : s_ff.chan;
                        nxt_s.start = 1'b1;
                        nxt_s.st    = ACS_CONV;
                    end else begin
                        nxt_s.st = ACS_IDLE;
                    end
                end
            end
            default: begin
                nxt_s.st = ACS_IDLE;
            end
        endcase
    end

    // ========================================================================
    // state register
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            s_ff        <= '0;
            s_ff.st     <= ACS_IDLE;
            s_ff.chan   <= `ACS_CH_VDD;
            s_ff.cfg1   <= `ACS_RST_CFG1;
            s_ff.cfg2   <= `ACS_RST_CFG2;
            s_ff.tofs   <= `ACS_RST_TOFS;
            s_ff.lim[0] <= `ACS_RST_LIM_IH;
            s_ff.lim[1] <= `ACS_RST_LIM_IL;
            s_ff.lim[2] <= `ACS_RST_LIM_EH;
            s_ff.lim[3] <= `ACS_RST_LIM_EL;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // ========================================================================
    // outputs
    assign rd_data_o    = s_ff.rdata;
    assign adc_start_o  = s_ff.start;
    assign adc_abort_o  = s_ff.abort;
    assign adc_chan_o   = s_ff.chan;
    assign ref_power_o  = s_ff.cfg1[`ACS_CFG1_MON];
    assign limit_flag_o = s_ff.flag;

endmodule // acs_sequencer

`default_nettype wire

// ==== test/acs_sequencer_assertions.sv ====
// checker: port-level timing of the adc channel sequencer.
// assumes it is bound to acs_sequencer, one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module acs_seq_chk
    import acs_pkg::*;
(
    // clock and reset
    input wire logic       ref_clk_i,
    input wire logic       rst_i,
    // register port
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wr_data_i,
    input wire logic       wr_i,
    input wire logic       rd_i,
    input wire logic [7:0] rd_data_o,
    // converter and flags
    input wire logic       host_busy_i,
    input wire logic       adc_done_i,
    input wire logic [9:0] adc_data_i,
    input wire logic       adc_start_o,
    input wire logic       adc_abort_o,
    input wire logic [3:0] adc_chan_o,
    input wire logic       ref_power_o,
    input wire logic [3:0] limit_flag_o
);
    logic [7:0] cfg1_ff;
    logic [7:0] cfg2_ff;
    logic       acc_ff;
    logic       acc;
    logic       ok_done;
    logic [3:0] rr_next;
    logic [3:0] fld;
    logic [3:0] run_ff;
    logic       tmp;
    logic [3:0] exp_chan;

    // ==========
    // shadow of the configuration, the registers are not visible at the ports
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cfg1_ff <= 8'h00;
            cfg2_ff <= 8'h00;
            acc_ff  <= 1'b0;
            run_ff  <= 4'h0;
        end else begin
            acc_ff <= acc;
            if (adc_abort_o) run_ff <= 4'h0;
            else if (ok_done) run_ff <= tmp ? run_ff + 4'h1 : 4'h0;
            if (wr_i && addr_i == 8'h18) cfg1_ff <= wr_data_i;
            if (wr_i && addr_i == 8'h19) cfg2_ff <= wr_data_i;
        end
    end

    // a done only counts when no access is open or has just closed
    assign acc     = wr_i | rd_i | host_busy_i;
    assign ok_done = adc_done_i && ref_power_o && !acc && !acc_ff;
    assign rr_next = (adc_chan_o == 4'h9) ? 4'h0 : (adc_chan_o == 4'h2 && !cfg1_ff[2]) ? 4'h4 : adc_chan_o + 4'h1;
    assign fld     = (cfg2_ff[3:0] > 4'h9) ? 4'h0 : (cfg2_ff[3:0] == 4'h3 && !cfg1_ff[2]) ? 4'h2 : cfg2_ff[3:0];
    // an averaged temperature slot repeats until sixteen samples are summed
    assign tmp      = !cfg2_ff[5] && (adc_chan_o == 4'h1 || (adc_chan_o == 4'h2 && !cfg1_ff[2]));
    assign exp_chan = (tmp && run_ff != 4'hf) ? adc_chan_o : rr_next;

    // ==========
    // properties
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);

    a_ref_follows: assert property (wr_i && addr_i == 8'h18 |=> ref_power_o == $past(wr_data_i[0]))
        else $error("reference power not following enable");
    a_off_no_start: assert property (!ref_power_o |-> !adc_start_o)
        else $error("start while monitoring off");
    a_access_holds: assert property (acc |=> !adc_start_o)
        else $error("start during host access");
    a_resume_start: assert property (ref_power_o && !acc && acc_ff |=> adc_start_o)
        else $error("no restart after access");
    a_done_restart: assert property (ok_done |=> adc_start_o ##1 !adc_start_o)
        else $error("no new start after done");
    a_rr_order: assert property (ok_done && !cfg2_ff[4] |=> adc_chan_o == $past(exp_chan))
        else $error("wrong round robin channel");
    a_single_chan: assert property (adc_start_o && cfg2_ff[4] |-> adc_chan_o == fld)
        else $error("wrong single channel");
    a_abort_access: assert property (acc && !acc_ff && ref_power_o |=> adc_abort_o)
        else $error("no abort on access");
    a_flags_hold: assert property (!$past(adc_done_i) |-> $stable(limit_flag_o))
        else $error("flags changed without result");

    c_rr_wrap: cover property (ok_done && !cfg2_ff[4] && adc_chan_o == 4'h9);
    c_abort: cover property (adc_abort_o && adc_data_i != 10'h000);
    c_single: cover property (adc_start_o && cfg2_ff[4] && rd_data_o != 8'h00);
endmodule // acs_seq_chk

bind acs_sequencer acs_seq_chk acs_seq_chk_i (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
    .rd_data_o(rd_data_o), .host_busy_i(host_busy_i), .adc_done_i(adc_done_i), .adc_data_i(adc_data_i),
    .adc_start_o(adc_start_o), .adc_abort_o(adc_abort_o), .adc_chan_o(adc_chan_o),
    .ref_power_o(ref_power_o), .limit_flag_o(limit_flag_o));
`default_nettype wire

// ==== test/acs_adc_model.sv ====
// converter model: one conversion per start, done after a variable delay.
// assumes start and abort are one-cycle pulses on ref_clk_i.
`timescale 1ns/1ps
`default_nettype none
module acs_adc_model (
    // clock and reset
    input wire logic            ref_clk_i,
    input wire logic            rst_i,
    // conversion control
    input wire logic            adc_start_i,
    input wire logic            adc_abort_i,
    input wire logic [3:0]      adc_chan_i,
    input wire logic [3:0]      dly_i,
    input wire logic [9:0][9:0] samp_i,
    // result
    output logic                adc_done_o,
    output logic [9:0]          adc_data_o
);
    logic [3:0] cnt_ff;
    logic [3:0] chan_ff;
    logic       busy_ff;

    // ==========
    // data line toggles outside done, so a stale value is never mistaken for a result
    always_ff @(posedge ref_clk_i) begin
        adc_done_o <= 1'b0;
        adc_data_o <= ~adc_data_o;
        if (rst_i || adc_abort_i) begin
            busy_ff    <= 1'b0;
            adc_data_o <= 10'h155;
        end else if (adc_start_i) begin
            busy_ff <= 1'b1;
            cnt_ff  <= dly_i;
            chan_ff <= adc_chan_i;
        end else if (busy_ff && cnt_ff == 4'h0) begin
            busy_ff    <= 1'b0;
            adc_done_o <= 1'b1;
            adc_data_o <= samp_i[chan_ff];
        end else if (busy_ff) begin
            cnt_ff <= cnt_ff - 4'h1;
        end
    end
endmodule // acs_adc_model
`default_nettype wire

// ==== test/acs_sequencer_bench.sv ====
// bench of the adc channel sequencer: registers, order, access halts, results.
// assumes acs_adc_model on the converter side and the bound checker.
`timescale 1ns/1ps
`default_nettype none
module acs_sequencer_bench import acs_pkg::*; ;
    logic            ref_clk;
    logic            rst, wr, rd, busy, done, start, abort, refp, rnd_on;
    logic [7:0]      addr, wdat, rdat, ofs;
    logic [3:0]      chan, flags, dly;
    logic [9:0]      adata, t1;
    logic [9:0][9:0] samp = '0;
    logic [3:0][7:0] lim  = {8'h00, 8'hff, 8'hc9, 8'h64};
    logic [15:0]     lfsr_ff = 16'h0e5f;
    logic [3:0]      seen_q[$];
    int              err_total = 0;
    int              n_compared = 0;
    int              cyc = 0;

    acs_sequencer acs_sequencer_i (.ref_clk_i(ref_clk), .rst_i(rst), .addr_i(addr), .wr_data_i(wdat),
        .wr_i(wr), .rd_i(rd), .rd_data_o(rdat), .host_busy_i(busy), .adc_done_i(done), .adc_data_i(adata),
        .adc_start_o(start), .adc_abort_o(abort), .adc_chan_o(chan), .ref_power_o(refp), .limit_flag_o(flags));
    acs_adc_model acs_adc_model_i (.ref_clk_i(ref_clk), .rst_i(rst), .adc_start_i(start), .adc_abort_i(abort),
        .adc_chan_i(chan), .dly_i(dly), .samp_i(samp), .adc_done_o(done), .adc_data_o(adata));

    // ==========
    // helpers
    function automatic logic [15:0] lfsr_next(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    function automatic logic [3:0] rr_exp(input logic [3:0] c, input logic pins);
        if (c == 4'h9) return 4'h0;
        return (c == 4'h2 && !pins) ? 4'h4 : c + 4'h1;
    endfunction
    function automatic logic [3:0] flags_exp(input logic [7:0] e);
        return {$signed(e) <= 0, $signed(e) > -1, 2'b01};
    endfunction
    task automatic chk(input string what, input logic [9:0] exp, input logic [9:0] got);
        n_compared = n_compared + 1;
        if (got !== exp) begin
            err_total = err_total + 1;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr <= a;
        wdat <= d;
        wr   <= 1'b1;
        @(posedge ref_clk);
        wr   <= 1'b0;
        @(posedge ref_clk);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        addr <= a;
        rd   <= 1'b1;
        @(posedge ref_clk);
        rd   <= 1'b0;
        @(negedge ref_clk);
        chk($sformatf("register %h", a), {2'b00, exp}, {2'b00, rdat});
        @(posedge ref_clk);
    endtask
    // the log is emptied mid-cycle so no start of the previous cycle slips in
    task automatic clear_log();
        @(negedge ref_clk);
        seen_q.delete();
        @(posedge ref_clk);
    endtask
    task automatic wait_starts(input int n);
        for (int i = 0; i < 20000 && seen_q.size() < n; i++) @(posedge ref_clk);
    endtask
    // averaged temperature slots repeat sixteen times; a partial first run is skipped
    task automatic check_order(input logic pins, input logic avg);
        int         j;
        int         run;
        logic [3:0] e;
        j   = 1;
        run = 1;
        while (j < 20 && seen_q[j] == seen_q[j-1]) j++;
        for (int i = j + 1; i < j + 61; i++) begin
            e   = (avg && run < 16 && (seen_q[i-1] == 4'h1 || (seen_q[i-1] == 4'h2 && !pins))) ?
                  seen_q[i-1] : rr_exp(seen_q[i-1], pins);
            run = (e == seen_q[i-1]) ? run + 1 : 1;
            chk("next channel", {6'h00, e}, {6'h00, seen_q[i]});
        end
    endtask
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // random converter delay and host activity, start log and watchdog
    always @(posedge ref_clk) begin
        lfsr_ff <= lfsr_next(lfsr_ff);
        dly     <= lfsr_ff[3:0];
        busy    <= rnd_on && lfsr_ff[7:5] == 3'h0;
        if (start === 1'b1) seen_q.push_back(chan);
        cyc = cyc + 1;
        if (cyc == 40000) begin
            err_total = err_total + 1;
            complete_run();
        end
    end

    // ==========
    // main sequence
    initial begin
        {rst, wr, rd, rnd_on} = 4'h8;
        {addr, wdat} = 16'h0000;
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        chk("reference power", 10'h000, {9'h000, refp});
        rd_chk(8'h18, 8'h00);
        rd_chk(8'h19, 8'h00);
        for (int i = 0; i < 4; i++) rd_chk(8'h25 + i[7:0], lim[i]);
        wr_reg(8'h02, 8'hff);
        rd_chk(8'h02, 8'h00);
        for (int i = 0; i < 10; i++) samp[i] = 10'(lfsr_next(lfsr_ff + 16'(i * 7919)));
        samp[1][9:8] = 2'b00;
        ofs = {5'h1f, lfsr_ff[2:0]};
        t1 = samp[1] + {{2{ofs[7]}}, ofs};
        wr_reg(8'h1f, ofs);
        wr_reg(8'h25, 8'h80);
        wr_reg(8'h26, 8'h80);
        clear_log();
        repeat (40) @(posedge ref_clk);
        chk("starts while off", 10'h000, 10'(seen_q.size()));
        wr_reg(8'h18, 8'h01);
        chk("reference power", 10'h001, {9'h000, refp});
        wait_starts(9 * 17 + 2);
        chk("first channel", 10'h000, {6'h00, seen_q[0]});
        check_order(1'b0, 1'b1);
        rd_chk(8'h06, samp[0][9:2]);
        rd_chk(8'h03, {4'h0, t1[1:0], samp[0][1:0]});
        rd_chk(8'h07, t1[9:2]);
        for (int i = 2; i < 10; i++) if (i != 3) rd_chk(8'h06 + i[7:0], samp[i][9:2]);
        chk("flags", {6'h00, flags_exp(samp[2][9:2])}, {6'h00, flags});
        rd_chk(8'h00, {4'h0, flags_exp(samp[2][9:2])});
        rnd_on <= 1'b1;
        for (int i = 0; i < 400; i++) begin
            if (lfsr_ff[15:13] == 3'h0) rd_chk(8'h06, samp[0][9:2]);
            else @(posedge ref_clk);
        end
        rnd_on <= 1'b0;
        for (int i = 0; i < 12; i++) begin
            wr_reg(8'h19, 8'h30 | i[7:0]);
            clear_log();
            wait_starts(3);
            chk("single channel", (i > 9) ? 10'h000 : (i == 3) ? 10'h002 : 10'(i), {6'h00, seen_q[2]});
        end
        samp[1] = {2'b00, lfsr_ff[7:0]};
        t1 = samp[1] + {{2{ofs[7]}}, ofs};
        wr_reg(8'h19, 8'h31);
        clear_log();
        wait_starts(3);
        rd_chk(8'h07, t1[9:2]);
        wr_reg(8'h19, 8'h20);
        wr_reg(8'h18, 8'h05);
        clear_log();
        wait_starts(80);
        check_order(1'b1, 1'b0);
        wr_reg(8'h18, 8'h00);
        chk("reference power", 10'h000, {9'h000, refp});
        clear_log();
        repeat (40) @(posedge ref_clk);
        chk("starts while off", 10'h000, 10'(seen_q.size()));
        complete_run();
    end
endmodule // acs_sequencer_bench
`default_nettype wire
